// *** rtl/asc_pkg.sv ***
// constants, register map and frame kinds of the async serial core
package asc_pkg;
	localparam int BAUD_DIV_W = 13;
	localparam int CLK_PER_BIT_FACTOR = 32;
	localparam int SAMPLES_PER_BIT = 16;
	localparam int CLK_PER_SAMPLE_FACTOR = CLK_PER_BIT_FACTOR / SAMPLES_PER_BIT;
	localparam int DATA_W = 9;
	localparam int FRAME_W = 11;
	localparam logic [3:0] FRAME_LEN_SHORT = 4'hA;
	localparam logic [3:0] FRAME_LEN_LONG = 4'hB;
	localparam logic [3:0] PHASE_LAST = 4'hF;
	localparam logic [3:0] PHASE_S1 = 4'h7;
	localparam logic [3:0] PHASE_S2 = 4'h8;
	localparam logic [3:0] PHASE_S3 = 4'h9;
	localparam logic [3:0] PHASE_DECIDE = 4'hA;
	localparam logic [3:0] PHASE_AFTER_EDGE = 4'h1;
	localparam logic [1:0] START_ONES_MIN = 2'h3;
	// register byte offsets
	localparam logic [7:0] OFS_BAUD = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0C;
	// serial_ctrl_one fields
	localparam int CB_SBK = 0;
	localparam int CB_RXEN = 1;
	localparam int CB_TXEN = 2;
	localparam int CB_RIE = 4;
	localparam int CB_TX_COMPLETE_IRQ_ENABLE = 5;
	localparam int CB_TIE = 6;
	localparam int CB_OD = 7;
	localparam int CB_LONG = 8;
	localparam int CB_PE = 9;
	localparam int CB_PODD = 10;
	localparam int CB_POUT = 11;
	localparam int CB_PDIR = 12;
	localparam int CTRL_W = 13;
	localparam logic [12:0] CTRL_RST = 13'h0000;
	localparam logic [12:0] BAUD_RST = 13'h0000;
	// serial_status_reg fields
	localparam int SB_PF = 0;
	localparam int SB_FE = 1;
	localparam int SB_NF = 2;
	localparam int SB_OR = 3;
	localparam int SB_RX_FULL_FLAG = 4;
	localparam int SB_TC = 5;
	localparam int SB_TX_EMPTY_FLAG = 6;
	localparam int STAT_W = 7;
	localparam logic [6:0] STAT_RST = 7'h60;
	typedef enum logic [1:0] {
		ASC_FK_DATA = 2'b00,
		ASC_FK_IDLE = 2'b01,
		ASC_FK_BREAK = 2'b10,
		ASC_FK_MARK = 2'b11
	} asc_frame_t;
	typedef enum logic [1:0] {
		ASC_RX_IDLE = 2'b00,
		ASC_RX_START = 2'b01,
		ASC_RX_DATA = 2'b10,
		ASC_RX_STOP = 2'b11
	} asc_rx_state_t;
endpackage

// *** rtl/asc_baud.sv ***
// baud generator: sample-rate tick at sixteen times the bit rate
module asc_baud import asc_pkg::*; #(
	parameter int DIV_W = BAUD_DIV_W
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic [DIV_W-1:0] i_divisor,
	output logic o_tick
);
	if (DIV_W < 1) $error("divisor width must be positive");
	logic [DIV_W:0] cnt_reg;
	logic [DIV_W:0] top;
	// bit rate = fclk / (32 * divisor), so a sample tick every 2 * divisor clocks
	assign top = (DIV_W+1)'(CLK_PER_SAMPLE_FACTOR) * {1'b0, i_divisor} - (DIV_W+1)'(1);
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_reg <= '0;
			o_tick <= 1'b0;
		end else if (i_divisor == '0) begin
			cnt_reg <= '0;
			o_tick <= 1'b0;
		end else if (cnt_reg >= top) begin
			cnt_reg <= '0;
			o_tick <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + (DIV_W+1)'(1);
			o_tick <= 1'b0;
		end
	end
endmodule

// *** rtl/asc_sync.sv ***
// three-stage input synchroniser; level accepted when stages two and three agree
module asc_sync (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_pin,
	output logic o_level
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			o_level <= 1'b1;
		end else begin
			s1_reg <= i_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				o_level <= s3_reg;
			end
		end
	end
endmodule

// *** rtl/asc_core.sv ***
// async serial transmitter/receiver core with apb register slave
// Functional notes
// - bit rate is clock over 32 times divisor
// - divisor zero stops the baud generator
// - sample at 16x, re-centre on line edges
// - parity select: 0 even, 1 odd, both directions
// - parity in top data position, generated and checked
// - length and parity pick 8, 7+p, 9, 8+p
// - shifter drives pin while enabled or busy
// - open-drain select applies to transmit pin
// - holding buffer; empty flag; rewrite overwrites
// - complete flag cleared by status read then write
// - enabling sends idle preamble, then sets complete
// - break frames while break set, after current frame
// - break end sets complete, then one mark bit
// - all sent and enabled: flags set, pin high
// - disable: finish pending, release pin, drop buffer
// - re-enable while busy: finish, preamble, continue
// - empty and complete raise enabled interrupt requests
// - stop bit moves data, sets full flag
// - error flags set only at the move
// - full at completion: overrun, data kept, no errors
// - status read arms, data read clears armed flags
// - full flag raises receive request when enabled
// - frame: start low, data lsb first, parity, stop
//
// The address map and the APB register port are this design's own decisions.
module asc_core import asc_pkg::*; #(
	parameter int DIV_W = BAUD_DIV_W
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_rxd,
	output logic o_txd_out,
	output logic o_txd_oe,
	output logic o_tx_irq,
	output logic o_rx_irq
);
	if (DIV_W < 1 || DIV_W > BAUD_DIV_W) $error("divisor width out of range");

	logic [DIV_W-1:0] baud_divisor_reg;
	logic [CTRL_W-1:0] serial_ctrl_one_reg;
	logic [STAT_W-1:0] serial_status_reg;
	logic [STAT_W-1:0] arm_reg;
	logic [DATA_W-1:0] tx_holding_reg;
	logic [DATA_W-1:0] rx_holding_reg;
	logic tick;
	logic rx_level;

	logic setup;
	logic access;
	logic wr_data;
	logic rd_data;
	logic rd_status;
	logic tx_accept;
	assign setup = i_psel & ~i_penable;
	assign access = i_psel & i_penable;
	assign wr_data = access & i_pwrite & (i_paddr == OFS_DATA);
	assign rd_data = access & ~i_pwrite & (i_paddr == OFS_DATA);
	assign rd_status = access & ~i_pwrite & (i_paddr == OFS_STATUS);
	// a data write with the empty flag set and not armed is dropped
	assign tx_accept = wr_data & (~serial_status_reg[SB_TX_EMPTY_FLAG] | arm_reg[SB_TX_EMPTY_FLAG]);

	logic tx_en;
	logic send_break;
	logic long_frame;
	logic par_en;
	logic par_odd;
	assign tx_en = serial_ctrl_one_reg[CB_TXEN];
	assign send_break = serial_ctrl_one_reg[CB_SBK];
	assign long_frame = serial_ctrl_one_reg[CB_LONG];
	assign par_en = serial_ctrl_one_reg[CB_PE];
	assign par_odd = serial_ctrl_one_reg[CB_PODD];

	asc_baud #(.DIV_W(DIV_W)) u_baud (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_divisor(baud_divisor_reg),
		.o_tick(tick)
	);

	asc_sync u_sync (
		.i_ref_clk(i_ref_clk),
		.i_rst(i_rst),
		.i_pin(i_rxd),
		.o_level(rx_level)
	);

	// apb: zero wait states, read data and error prepared in the setup cycle
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_prdata <= 32'h00000000;
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready <= 1'b1;
			if (setup) begin
				o_pslverr <= 1'b0;
				unique case (i_paddr)
					OFS_BAUD: o_prdata <= 32'(baud_divisor_reg);
					OFS_CTRL: o_prdata <= 32'(serial_ctrl_one_reg);
					OFS_STATUS: o_prdata <= 32'(serial_status_reg);
					OFS_DATA: o_prdata <= 32'(rx_holding_reg);
					default: begin
						o_prdata <= 32'h00000000;
						o_pslverr <= 1'b1;
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			baud_divisor_reg <= DIV_W'(BAUD_RST);
			serial_ctrl_one_reg <= CTRL_RST;
		end else if (access & i_pwrite) begin
			if (i_paddr == OFS_BAUD) begin
				baud_divisor_reg <= i_pwdata[DIV_W-1:0];
			end
			if (i_paddr == OFS_CTRL) begin
				serial_ctrl_one_reg <= i_pwdata[CTRL_W-1:0];
			end
		end
	end

	// status read snapshots the set flags; the matching data access clears them
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			arm_reg <= '0;
		end else if (rd_status) begin
			arm_reg <= serial_status_reg;
		end else if (rd_data) begin
			arm_reg[SB_RX_FULL_FLAG:SB_PF] <= '0;
		end else if (wr_data) begin
			arm_reg[SB_TX_EMPTY_FLAG:SB_TC] <= '0;
		end
	end

	// transmitter
	logic [FRAME_W-1:0] tx_shift_reg;
	logic [3:0] tx_left_reg;
	logic [3:0] tx_phase_reg;
	asc_frame_t tx_kind_reg;
	logic tx_drive_reg;
	logic te_d_reg;
	logic pre_pend_reg;
	logic brk_was_reg;
	logic tx_step;
	logic tx_load;
	asc_frame_t nxt_kind;
	logic [FRAME_W-1:0] nxt_frame;
	logic [3:0] nxt_len;
	logic [3:0] frame_len;
	logic [DATA_W-1:0] tx_word;
	logic tx_par;

	assign frame_len = long_frame ? FRAME_LEN_LONG : FRAME_LEN_SHORT;
	assign tx_par = ^(long_frame ? tx_holding_reg[7:0] : {1'b0, tx_holding_reg[6:0]}) ^ par_odd;
	always_comb begin
		tx_word = tx_holding_reg;
		if (par_en) begin
			if (long_frame) begin
				tx_word[8] = tx_par;
			end else begin
				tx_word[7] = tx_par;
			end
		end
		if (!long_frame) begin
			tx_word[8] = 1'b1;
		end
	end
	assign tx_step = tick & ((tx_left_reg == 4'h0) | ((tx_phase_reg == PHASE_LAST)
		& (tx_left_reg == 4'h1)));

	always_comb begin
		tx_load = 1'b1;
		nxt_kind = ASC_FK_DATA;
		nxt_len = frame_len;
		nxt_frame = {1'b1, tx_word, 1'b0};
		if (pre_pend_reg) begin
			nxt_kind = ASC_FK_IDLE;
			nxt_frame = '1;
		end else if (send_break & tx_en) begin
			nxt_kind = ASC_FK_BREAK;
			nxt_frame = '0;
		end else if (brk_was_reg) begin
			nxt_kind = ASC_FK_MARK;
			nxt_frame = '1;
			nxt_len = 4'h1;
		end else if (!(tx_en & ~serial_status_reg[SB_TX_EMPTY_FLAG])) begin
			tx_load = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_shift_reg <= '1;
			tx_left_reg <= 4'h0;
			tx_phase_reg <= 4'h0;
			tx_kind_reg <= ASC_FK_IDLE;
			tx_drive_reg <= 1'b0;
			brk_was_reg <= 1'b0;
		end else if (tx_step) begin
			tx_phase_reg <= 4'h0;
			if (tx_load) begin
				tx_shift_reg <= nxt_frame;
				tx_left_reg <= nxt_len;
				tx_kind_reg <= nxt_kind;
				tx_drive_reg <= 1'b1;
				brk_was_reg <= (nxt_kind == ASC_FK_BREAK);
			end else begin
				tx_shift_reg <= '1;
				tx_left_reg <= 4'h0;
				tx_drive_reg <= tx_en;
			end
		end else if (tick) begin
			tx_phase_reg <= tx_phase_reg + 4'h1;
			if (tx_phase_reg == PHASE_LAST && tx_left_reg > 4'h1) begin
				tx_shift_reg <= {1'b1, tx_shift_reg[FRAME_W-1:1]};
				tx_left_reg <= tx_left_reg - 4'h1;
			end
		end
	end

	// preamble queued on each enable edge, even while a frame is still going
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			te_d_reg <= 1'b0;
			pre_pend_reg <= 1'b0;
		end else begin
			te_d_reg <= tx_en;
			if (tx_step & tx_load & (nxt_kind == ASC_FK_IDLE)) begin
				pre_pend_reg <= 1'b0;
			end
			if (tx_en & ~te_d_reg) begin
				pre_pend_reg <= 1'b1;
			end
		end
	end

	logic frame_done;
	logic tc_set;
	assign frame_done = tx_step & (tx_left_reg != 4'h0);
	assign tc_set = frame_done & ((tx_kind_reg == ASC_FK_IDLE) | ~tx_load
		| ((tx_kind_reg == ASC_FK_BREAK) & (nxt_kind != ASC_FK_BREAK)));

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			tx_holding_reg <= '0;
			serial_status_reg[SB_TX_EMPTY_FLAG] <= STAT_RST[SB_TX_EMPTY_FLAG];
		end else begin
			if (tx_accept) begin
				tx_holding_reg <= i_pwdata[DATA_W-1:0];
				serial_status_reg[SB_TX_EMPTY_FLAG] <= 1'b0;
			end
			if (tx_step & tx_load & (nxt_kind == ASC_FK_DATA)) begin
				serial_status_reg[SB_TX_EMPTY_FLAG] <= 1'b1;
			end
			if (tx_step & ~tx_en) begin
				serial_status_reg[SB_TX_EMPTY_FLAG] <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			serial_status_reg[SB_TC] <= STAT_RST[SB_TC];
		end else begin
			if (wr_data & arm_reg[SB_TC]) begin
				serial_status_reg[SB_TC] <= 1'b0;
			end
			if (tx_step & tx_load & (nxt_kind == ASC_FK_IDLE || nxt_kind == ASC_FK_BREAK)) begin
				serial_status_reg[SB_TC] <= 1'b0;
			end
			if (tc_set) begin
				serial_status_reg[SB_TC] <= 1'b1;
			end
		end
	end

	// pin: transmitter owns it while driving, otherwise the port bits do
	logic pin_val;
	logic pin_en;
	assign pin_val = tx_drive_reg ? tx_shift_reg[0] : serial_ctrl_one_reg[CB_POUT];
	assign pin_en = tx_drive_reg | serial_ctrl_one_reg[CB_PDIR];
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_txd_out <= 1'b1;
			o_txd_oe <= 1'b0;
		end else begin
			o_txd_out <= pin_val;
			o_txd_oe <= pin_en & (~serial_ctrl_one_reg[CB_OD] | ~pin_val);
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			o_tx_irq <= 1'b0;
			o_rx_irq <= 1'b0;
		end else begin
			o_tx_irq <= (serial_status_reg[SB_TX_EMPTY_FLAG] & serial_ctrl_one_reg[CB_TIE])
				| (serial_status_reg[SB_TC] & serial_ctrl_one_reg[CB_TX_COMPLETE_IRQ_ENABLE]);
			o_rx_irq <= serial_status_reg[SB_RX_FULL_FLAG] & serial_ctrl_one_reg[CB_RIE];
		end
	end

	// receiver
	asc_rx_state_t rx_state_reg;
	logic [3:0] rx_phase_reg;
	logic [3:0] rx_idx_reg;
	logic [1:0] ones_reg;
	logic [2:0] smp_reg;
	logic rx_last_reg;
	logic rx_noise_reg;
	logic [DATA_W-1:0] rx_shift_reg;
	logic maj;
	logic noisy;
	logic edge_seen;
	logic decide;
	logic rx_done;
	logic [DATA_W-1:0] rx_word;
	logic rx_pf;
	logic [3:0] data_bits;

	assign maj = (smp_reg[0] & smp_reg[1]) | (smp_reg[0] & smp_reg[2])
		| (smp_reg[1] & smp_reg[2]);
	assign noisy = ~(&smp_reg) & (|smp_reg);
	assign edge_seen = tick & (rx_level != rx_last_reg);
	assign decide = tick & (rx_phase_reg == PHASE_DECIDE) & (rx_state_reg != ASC_RX_IDLE);
	assign data_bits = long_frame ? 4'h9 : 4'h8;
	assign rx_done = decide & (rx_state_reg == ASC_RX_STOP);
	assign rx_word = long_frame ? rx_shift_reg : {1'b0, rx_shift_reg[DATA_W-1:1]};
	assign rx_pf = par_en & ((^rx_word) != par_odd);

	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_state_reg <= ASC_RX_IDLE;
			rx_phase_reg <= 4'h0;
			rx_idx_reg <= 4'h0;
			ones_reg <= 2'h0;
			smp_reg <= 3'h7;
			rx_last_reg <= 1'b1;
			rx_noise_reg <= 1'b0;
			rx_shift_reg <= '0;
		end else if (!serial_ctrl_one_reg[CB_RXEN]) begin
			rx_state_reg <= ASC_RX_IDLE;
			ones_reg <= 2'h0;
		end else if (tick) begin
			rx_last_reg <= rx_level;
			rx_phase_reg <= rx_phase_reg + 4'h1;
			if (edge_seen && (rx_phase_reg > PHASE_DECIDE || rx_phase_reg < PHASE_S1 - 4'h1)) begin
				rx_phase_reg <= PHASE_AFTER_EDGE;
			end
			if (rx_phase_reg == PHASE_S1) smp_reg[0] <= rx_level;
			if (rx_phase_reg == PHASE_S2) smp_reg[1] <= rx_level;
			if (rx_phase_reg == PHASE_S3) smp_reg[2] <= rx_level;
			unique case (rx_state_reg)
				ASC_RX_IDLE: begin
					if (rx_level) begin
						ones_reg <= (ones_reg == START_ONES_MIN) ? ones_reg : ones_reg + 2'h1;
					end else if (ones_reg == START_ONES_MIN) begin
						rx_state_reg <= ASC_RX_START;
						rx_phase_reg <= PHASE_AFTER_EDGE;
						rx_noise_reg <= 1'b0;
						rx_idx_reg <= 4'h0;
					end else begin
						ones_reg <= 2'h0;
					end
				end
				ASC_RX_START: begin
					if (decide) begin
						rx_noise_reg <= noisy;
						rx_state_reg <= maj ? ASC_RX_IDLE : ASC_RX_DATA;
						ones_reg <= 2'h0;
					end
				end
				ASC_RX_DATA: begin
					if (decide) begin
						rx_noise_reg <= rx_noise_reg | noisy;
						rx_shift_reg <= {maj, rx_shift_reg[DATA_W-1:1]};
						rx_idx_reg <= rx_idx_reg + 4'h1;
						if (rx_idx_reg + 4'h1 == data_bits) begin
							rx_state_reg <= ASC_RX_STOP;
						end
					end
				end
				ASC_RX_STOP: begin
					if (decide) begin
						rx_state_reg <= ASC_RX_IDLE;
						ones_reg <= maj ? START_ONES_MIN : 2'h0;
					end
				end
			endcase
		end
	end

	// frame completion: move or overrun, errors only with a move
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst) begin
			rx_holding_reg <= '0;
			serial_status_reg[SB_RX_FULL_FLAG:SB_PF] <= STAT_RST[SB_RX_FULL_FLAG:SB_PF];
		end else begin
			if (rd_data) begin
				serial_status_reg[SB_RX_FULL_FLAG:SB_PF] <= serial_status_reg[SB_RX_FULL_FLAG:SB_PF]
					& ~arm_reg[SB_RX_FULL_FLAG:SB_PF];
			end
			if (rx_done) begin
				if (serial_status_reg[SB_RX_FULL_FLAG] & ~(rd_data & arm_reg[SB_RX_FULL_FLAG])) begin
					serial_status_reg[SB_OR] <= 1'b1;
				end else begin
					rx_holding_reg <= rx_word;
					serial_status_reg[SB_RX_FULL_FLAG] <= 1'b1;
					serial_status_reg[SB_OR] <= 1'b0;
					serial_status_reg[SB_NF] <= rx_noise_reg | noisy;
					serial_status_reg[SB_FE] <= ~maj;
					serial_status_reg[SB_PF] <= rx_pf;
				end
			end
		end
	end
endmodule

// *** test/asc_core_sva.sv ***
// port checker for the async serial core
module asc_core_chk import asc_pkg::*; #(
	parameter int DIV_W = BAUD_DIV_W
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic i_rxd,
	input wire logic o_txd_out,
	input wire logic o_txd_oe,
	input wire logic o_tx_irq,
	input wire logic o_rx_irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);
	logic [12:0] ctrl_q;
	logic [15:0] low_cnt;
	logic acc, unmapped, tx_ie;
	assign acc = i_psel && i_penable && o_pready;
	assign unmapped = i_paddr > OFS_DATA || i_paddr[1:0] != 2'h0;
	assign tx_ie = ctrl_q[CB_TIE] | ctrl_q[CB_TX_COMPLETE_IRQ_ENABLE];
	// shadow of the control register as written over the bus
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			ctrl_q <= 13'h0000;
		else if (acc && i_pwrite && i_paddr == OFS_CTRL)
			ctrl_q <= i_pwdata[12:0];
	end
	// length of the current driven-low run on the transmit pin
	always_ff @(posedge i_ref_clk or posedge i_rst) begin
		if (i_rst)
			low_cnt <= 16'h0000;
		else if (o_txd_oe && !o_txd_out)
			low_cnt <= low_cnt + 16'h0001;
		else
			low_cnt <= 16'h0000;
	end
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	sequence s_access;
		i_psel && i_penable;
	endsequence
	chk_zero_wait: assert property (s_setup ##1 s_access |-> o_pready)
		else $error("access phase without ready");
	chk_slverr_map: assert property (acc |-> o_pslverr == unmapped)
		else $error("slave error does not match map");
	chk_unmapped_zero: assert property (acc && !i_pwrite && unmapped |-> o_prdata == 32'h0)
		else $error("unmapped read not zero");
	chk_bit_quantum: assert property (
		low_cnt != 16'h0 && !(o_txd_oe && !o_txd_out) |-> low_cnt[4:0] == 5'h00)
		else $error("low run not whole bits");
	chk_open_drain: assert property (
		ctrl_q[CB_OD] && $past(ctrl_q[CB_OD], 2) && o_txd_oe |-> !o_txd_out)
		else $error("open drain drives high");
	chk_tx_irq_mask: assert property ((!tx_ie) [*2] |-> !o_tx_irq)
		else $error("tx request while disabled");
	chk_rx_irq_mask: assert property ((!ctrl_q[CB_RIE]) [*2] |-> !o_rx_irq)
		else $error("rx request while disabled");
	chk_reset_idle: assert property ($fell(i_rst) |-> o_txd_out && !o_txd_oe && !o_rx_irq)
		else $error("pin or request active after reset");
endmodule

bind asc_core asc_core_chk #(.DIV_W(DIV_W)) asc_core_chk_inst (.i_ref_clk, .i_rst, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rxd,
	.o_txd_out, .o_txd_oe, .o_tx_irq, .o_rx_irq);

// *** test/asc_line_model.sv ***
// remote serial device: drives the receive line, samples the transmit line
module asc_line_model (
	input wire logic i_ref_clk,
	input wire logic i_pin,
	output logic o_rxd
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [10:0] got;
	initial o_rxd = 1'h1;
	// start bit, bits lsb first, then one idle bit; 32 clocks a bit
	task automatic send(input logic [10:0] w, input int n);
		repeat (32) @(posedge i_ref_clk) o_rxd <= 1'h0;
		for (int i = 0; i < n; i++)
			repeat (32) @(posedge i_ref_clk) o_rxd <= w[i];
		repeat (32) @(posedge i_ref_clk) o_rxd <= 1'h1;
	endtask
	// samples mid-bit, timed from the start edge
	task automatic grab(input int n);
		got = 11'h0;
		@(negedge i_pin);
		repeat (16) @(posedge i_ref_clk);
		for (int i = 0; i < n; i++) begin
			repeat (32) @(posedge i_ref_clk);
			got[i] = i_pin;
		end
	endtask
endmodule

// *** test/async_serial_tx_rx_core_bench.sv ***
// self-checking bench for the async serial core
module async_serial_tx_rx_core_bench import asc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0;
	logic pen = 1'h0;
	logic pwr = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, serr, txd_out, txd_oe, tx_irq, rx_irq, rxd;
	logic [8:0] d;
	// pull-up on the transmit pin
	wire line = txd_oe ? txd_out : 1'h1;
	int err_count = 0;
	int checks = 0;
	int n;
	initial forever #2 clk = ~clk;
	asc_core asc_core_inst (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_rxd(rxd), .o_txd_out(txd_out),
		.o_txd_oe(txd_oe), .o_tx_irq(tx_irq), .o_rx_irq(rx_irq));
	asc_line_model asc_line_model_inst (.i_ref_clk(clk), .i_pin(line), .o_rxd(rxd));
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		psel <= 1'h1;
		pwr <= w;
		paddr <= a;
		pwdata <= v;
		@(posedge clk);
		pen <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'h0;
		pen <= 1'h0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk($sformatf("read %h", a), e, rd);
	endtask
	// compares only the k data positions of the holding register
	task automatic rdd(input logic [10:0] w, input int k);
		apb(1'h0, OFS_DATA, 32'h0);
		chk("rx data", 32'(w & ((11'h1 << k) - 11'h1)), rd & ((32'h1 << k) - 32'h1));
	endtask
	task automatic send_tx(input logic [8:0] v);
		apb(1'h0, OFS_STATUS, 32'h0);
		apb(1'h1, OFS_DATA, {23'h0, v});
	endtask
	// f: bit 0 long frame, bit 1 parity on, bit 2 odd parity
	function automatic logic [10:0] frame(input logic [8:0] v, input int f);
		int nd;
		logic [10:0] w;
		nd = f[0] ? 9 : 8;
		w = {2'h0, v} & ((11'h1 << nd) - 11'h1);
		if (f[1])
			w[nd-1] = ^(w & ((11'h1 << (nd - 1)) - 11'h1)) ^ f[2];
		w[nd] = 1'h1;
		return w;
	endfunction
	initial begin
		repeat (40000) @(posedge clk);
		err_count++;
		finish_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'h0;
		rdc(OFS_STATUS, 32'h60);
		rdc(OFS_CTRL, 32'h0);
		rdc(8'h10, 32'h0);
		chk("slave error", 32'h1, {31'h0, serr});
		apb(1'h1, OFS_BAUD, 32'h1);
		apb(1'h1, OFS_CTRL, 32'h56);
		repeat (100) @(posedge clk);
		rdc(OFS_STATUS, 32'h40);
		chk("tx irq", 32'h1, {31'h0, tx_irq});
		repeat (400) @(posedge clk);
		rdc(OFS_STATUS, 32'h60);
		$display("reset and preamble test done");
		for (int f = 0; f < 8; f++) begin
			d = 9'h1A5 ^ 9'(f * 37);
			apb(1'h1, OFS_CTRL, 32'h56 | 32'(f) << 8);
			fork
				asc_line_model_inst.grab(9 + f[0]);
				begin
					send_tx(d);
					rdc(OFS_STATUS, 32'h40);
				end
			join
			chk("tx frame", 32'(frame(d, f)), 32'(asc_line_model_inst.got));
			asc_line_model_inst.send(frame(d, f), 9 + f[0]);
			rdc(OFS_STATUS, 32'h70);
			chk("rx irq", 32'h1, {31'h0, rx_irq});
			rdd(frame(d, f), 8 + f[0] - f[1]);
			rdc(OFS_STATUS, 32'h60);
		end
		$display("format test done");
		d = 9'h0C3;
		asc_line_model_inst.send(frame(d, 7) ^ 11'h100, 10);
		rdc(OFS_STATUS, 32'h71);
		rdd(frame(d, 7), 8);
		asc_line_model_inst.send(frame(d, 7) ^ 11'h200, 10);
		rdc(OFS_STATUS, 32'h72);
		rdd(frame(d, 7), 8);
		asc_line_model_inst.send(frame(d, 7), 10);
		asc_line_model_inst.send(frame(9'h05A, 7), 10);
		rdc(OFS_STATUS, 32'h78);
		rdd(frame(d, 7), 8);
		rdc(OFS_STATUS, 32'h60);
		$display("receive error test done");
		apb(1'h1, OFS_CTRL, 32'h757);
		n = 0;
		// count from the break request so the whole break frame is seen
		fork
			begin
				repeat (10) @(posedge clk);
				apb(1'h1, OFS_CTRL, 32'h756);
			end
			repeat (1000) @(posedge clk) n += int'(line === 1'h0);
		join
		chk("break span", 32'h160, 32'(n));
		rdc(OFS_STATUS, 32'h60);
		$display("break test done");
		apb(1'h1, OFS_CTRL, 32'h7D6);
		d = 9'h0F0;
		fork
			asc_line_model_inst.grab(10);
			begin
				send_tx(d);
				send_tx(9'h033);
				apb(1'h1, OFS_CTRL, 32'h7D2);
			end
		join
		chk("last frame", 32'(frame(d, 7)), 32'(asc_line_model_inst.got));
		n = 0;
		repeat (800) @(posedge clk) n += int'(line === 1'h0);
		chk("held data dropped", 32'h0, 32'(n));
		chk("pin released", 32'h0, {31'h0, txd_oe});
		rdc(OFS_STATUS, 32'h60);
		$display("disable test done");
		apb(1'h1, OFS_BAUD, 32'h0);
		apb(1'h1, OFS_CTRL, 32'h56);
		send_tx(9'h055);
		repeat (200) @(posedge clk);
		rdc(OFS_STATUS, 32'h00);
		chk("stopped pin", 32'h1, {31'h0, line});
		$display("stopped divisor test done");
		finish_test();
	end
endmodule
